/* File: core/ecc_seq_pkg.sv */
// Package for the memory correction and measurement sequencer.
// Assumes a single 20 MHz system clock and a 128 x 16 word memory.
package ecc_seq_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned MEM_WORDS = 128;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned DATA_W = 11;
  // Word layout: data in 15..5, overall parity at 4, check bits 3..0.
  localparam int unsigned DATA_LSB = 5;
  localparam int unsigned PAR_POS = 4;
  localparam int unsigned CHK_W = 4;
  // Memory word offsets: configuration, thresholds and user scratch.
  localparam logic [6:0] IR_GAIN_CONFIG_A = 7'h00;
  localparam logic [6:0] IR_GAIN_CONFIG_B = 7'h01;
  localparam logic [6:0] AMBIENT_GAIN_CONFIG = 7'h02;
  localparam logic [6:0] MAIN_CONFIG_A = 7'h03;
  localparam logic [6:0] MAIN_CONFIG_B = 7'h04;
  localparam logic [6:0] OSCILLATOR_CONFIG = 7'h05;
  localparam logic [6:0] BANDGAP_CONFIG = 7'h06;
  localparam logic [6:0] AVERAGING_CONFIG = 7'h07;
  localparam logic [6:0] COMPARATOR_ONE_THRESHOLD = 7'h73;
  localparam logic [6:0] COMPARATOR_ONE_HYSTERESIS = 7'h74;
  localparam logic [6:0] RELAY_THRESHOLD = 7'h75;
  localparam logic [6:0] RELAY_HYSTERESIS = 7'h76;
  localparam logic [6:0] USER_SCRATCH_WORDS = 7'h78;
  localparam logic [6:0] CONFIG_LAST = 7'h07;
  // Field positions inside the stored words.
  localparam int unsigned INTERVAL_LSB = 5;   // Four bits 8..5 of word 04h.
  localparam int unsigned IR_OFS_BIT = 12;    // Word 07h.
  localparam int unsigned AMB_OFS_BIT = 11;   // Word 07h.
  localparam int unsigned IR_AVG_LSB = 8;     // Bits 10..8 of word 07h.
  localparam int unsigned AMB_AVG_LSB = 5;    // Bits 7..5 of word 07h.
  localparam int unsigned FATAL_BIT = 1;      // Status nibble bit.
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  // Offset and measurement sample counts, offset durations.
  localparam int unsigned OFS_SMALL_N = 512;
  localparam int unsigned OFS_LARGE_N = 1024;
  localparam int unsigned OFS_SMALL_MS = 75;
  localparam int unsigned OFS_LARGE_MS = 150;
  localparam int unsigned OFS_SMALL_CYC = OFS_SMALL_MS * (CLK_HZ / 1000);
  localparam int unsigned OFS_LARGE_CYC = OFS_LARGE_MS * (CLK_HZ / 1000);
  localparam int unsigned MEAS_MIN_N = 64;
  localparam int unsigned MEAS_MAX_N = 1024;
  // Base offset interval; the selected interval is (select + 1) times this.
  localparam int unsigned INTERVAL_BASE_MS = 1000;
  localparam int unsigned INTERVAL_BASE_CYC =
    INTERVAL_BASE_MS * (CLK_HZ / 1000);
  typedef enum logic [2:0] {
    ST_SCAN_RD = 3'b000,
    ST_SCAN_WR = 3'b001,
    ST_INIT = 3'b011,
    ST_OFFSET = 3'b010,
    ST_MEASURE = 3'b110,
    ST_LINEAR = 3'b111,
    ST_COMPARE = 3'b101
  } seq_state_t;
endpackage : ecc_seq_pkg

/* File: core/ecc_startup_sequencer.sv */
// Memory word correction scan, configuration load and main sequencer.
// Assumes samples arrive as one-cycle strobes synchronous to CLK_SYS_IN and
// that the memory port is shared: the host may write only in normal run.
//
// Operation
// - Eleven data bits high, overall parity at bit four, check bits low.
// - Four check bits are parities over fixed subsets of the data bits.
// - Overall parity covers all data bits plus the four check bits.
// - Parity is one when covered bits hold an odd count of ones.
// - Correction scan runs once after reset and reads every address.
// - Single-bit errors are corrected and written back into memory.
// - Double errors leave the word and set the fatal flag, status bit one.
// - After the scan, words 00h to 07h load the configuration registers.
// - Sequencer runs correction, init, offset, measure, linearise, compare.
// - Offset measurement repeats at one of sixteen selectable intervals.
// - Offset measurement averages 512 or 1024 samples per channel.
// - Offset measurement lasts about 75 ms or 150 ms.
// - Outputs hold their last values during offset measurement.
// - Averaged offsets are stored in IR and ambient offset registers.
// - Measurement averages 64 to 1024 samples, set per channel.
// - Offset is subtracted; offset-free results go to result registers.
// - Fatal flag appears at bit one of the separate STATUS_OUT nibble.
module ecc_startup_sequencer
  import ecc_seq_pkg::*;
#(
  parameter int unsigned OFS_SMALL_CYCLES = OFS_SMALL_CYC,
  parameter int unsigned OFS_LARGE_CYCLES = OFS_LARGE_CYC,
  parameter int unsigned INTERVAL_CYCLES = INTERVAL_BASE_CYC
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic HOST_WR_IN,
  input wire logic [6:0] HOST_ADDR_IN,
  input wire logic [15:0] HOST_WDATA_IN,
  output logic [15:0] HOST_RDATA_OUT,
  input wire logic IR_SAMPLE_VALID_IN,
  input wire logic [11:0] IR_SAMPLE_IN,
  input wire logic AMB_SAMPLE_VALID_IN,
  input wire logic [11:0] AMB_SAMPLE_IN,
  output logic [15:0] IR_RESULT_OUT,
  output logic [15:0] AMB_RESULT_OUT,
  output logic [15:0] IR_OFFSET_OUT,
  output logic [15:0] AMB_OFFSET_OUT,
  output logic [3:0] STATUS_OUT,
  output logic RESULT_VALID_OUT,
  output logic OFFSET_BUSY_OUT,
  output logic SCAN_DONE_OUT,
  output logic [15:0] CONFIG_WORD_OUT [0:7]
);

  logic [15:0] mem [0:MEM_WORDS-1];
  seq_state_t state_reg, state_next;
  logic [6:0] addr_reg;
  logic fatal_reg;
  logic [15:0] cfg_reg [0:7];
  logic [15:0] ir_ofs_reg, amb_ofs_reg, ir_res_reg, amb_res_reg;
  logic [21:0] ir_acc_reg, amb_acc_reg;
  logic [10:0] ir_cnt_reg, amb_cnt_reg;
  logic [22:0] time_reg;
  logic [28:0] intv_reg;
  logic [15:0] fix_reg;
  logic valid_reg, busy_reg, done_reg;

  // Decode of the word under the scan pointer.
  // The memory is read without a register so each clean word costs one cycle.
  wire [15:0] word = mem[addr_reg];
  wire [10:0] d = word[15:DATA_LSB];
  wire [3:0] c_calc;
  assign c_calc[0] = ^{d[0], d[1], d[3], d[4], d[6], d[8], d[10]};
  assign c_calc[1] = ^{d[0], d[2], d[3], d[5], d[6], d[9], d[10]};
  assign c_calc[2] = ^{d[1], d[2], d[3], d[7], d[8], d[9], d[10]};
  assign c_calc[3] = ^{d[4], d[5], d[6], d[7], d[8], d[9], d[10]};
  wire [3:0] syndrome = c_calc ^ word[CHK_W-1:0];
  // Parity over all sixteen stored bits is zero for a clean word.
  wire par_bad = ^word;
  wire single_err = par_bad;
  wire double_err = (syndrome != 4'h0) && !par_bad;

  // Syndrome value names the codeword position of the wrong bit: positions
  // 1,2,4,8 are check bits, the rest data bits in ascending order.
  function automatic logic [15:0] flip_mask(input logic [3:0] s);
    logic [15:0] m;
    m = 16'h0000;
    case (s)
      4'h0: m = 16'h0010; // Only the overall parity bit is wrong.
      4'h1: m = 16'h0001;
      4'h2: m = 16'h0002;
      4'h4: m = 16'h0004;
      4'h8: m = 16'h0008;
      4'h3: m = 16'h0020;
      4'h5: m = 16'h0040;
      4'h6: m = 16'h0080;
      4'h7: m = 16'h0100;
      4'h9: m = 16'h0200;
      4'hA: m = 16'h0400;
      4'hB: m = 16'h0800;
      4'hC: m = 16'h1000;
      4'hD: m = 16'h2000;
      4'hE: m = 16'h4000;
      4'hF: m = 16'h8000;
      default: m = 16'h0000;
    endcase
    return m;
  endfunction

  // Configuration fields steering the sequencer.
  // Fields are taken from the raw coded words, so data bits sit at 15..5.
  wire [3:0] intv_sel = cfg_reg[4][INTERVAL_LSB+3:INTERVAL_LSB];
  wire ir_large = cfg_reg[7][IR_OFS_BIT];
  wire amb_large = cfg_reg[7][AMB_OFS_BIT];
  wire [10:0] ir_ofs_n = ir_large ? 11'(OFS_LARGE_N) : 11'(OFS_SMALL_N);
  wire [10:0] amb_ofs_n = amb_large ? 11'(OFS_LARGE_N) : 11'(OFS_SMALL_N);
  // Measurement count is 64 shifted by the 3-bit select, capped at 1024.
  wire [2:0] ir_avg_sel = cfg_reg[7][IR_AVG_LSB+2:IR_AVG_LSB];
  wire [2:0] amb_avg_sel = cfg_reg[7][AMB_AVG_LSB+2:AMB_AVG_LSB];
  wire [2:0] ir_sh = (ir_avg_sel > 3'h4) ? 3'h4 : ir_avg_sel;
  wire [2:0] amb_sh = (amb_avg_sel > 3'h4) ? 3'h4 : amb_avg_sel;
  wire [10:0] ir_meas_n = 11'(MEAS_MIN_N) << ir_sh;
  wire [10:0] amb_meas_n = 11'(MEAS_MIN_N) << amb_sh;
  wire offset_phase = (state_reg == ST_OFFSET);
  wire [10:0] ir_goal = offset_phase ? ir_ofs_n : ir_meas_n;
  wire [10:0] amb_goal = offset_phase ? amb_ofs_n : amb_meas_n;
  wire ir_full = (ir_cnt_reg == ir_goal);
  wire amb_full = (amb_cnt_reg == amb_goal);
  // Offset phase also waits for the documented duration.
  wire [22:0] ofs_time = (ir_large || amb_large) ?
    23'(OFS_LARGE_CYCLES) : 23'(OFS_SMALL_CYCLES);
  wire ofs_time_up = (time_reg >= ofs_time);
  wire [28:0] intv_goal = 29'(INTERVAL_CYCLES) * (29'(intv_sel) + 29'h1);
  wire intv_due = (intv_reg >= intv_goal);
  wire collecting = (state_reg == ST_OFFSET) || (state_reg == ST_MEASURE);
  wire ir_take = collecting && IR_SAMPLE_VALID_IN && !ir_full;
  wire amb_take = collecting && AMB_SAMPLE_VALID_IN && !amb_full;
  // Mean by shift; counts are powers of two so no divider is needed.
  wire [3:0] ir_log = offset_phase ? (ir_large ? 4'hA : 4'h9) :
    (4'h6 + {1'b0, ir_sh});
  wire [3:0] amb_log = offset_phase ? (amb_large ? 4'hA : 4'h9) :
    (4'h6 + {1'b0, amb_sh});
  wire [15:0] ir_mean = 16'(ir_acc_reg >> ir_log);
  wire [15:0] amb_mean = 16'(amb_acc_reg >> amb_log);
  wire [15:0] ir_free = ir_mean - ir_ofs_reg;
  wire [15:0] amb_free = amb_mean - amb_ofs_reg;
  wire host_wr_ok = HOST_WR_IN && (state_reg != ST_SCAN_RD) &&
    (state_reg != ST_SCAN_WR) && (state_reg != ST_INIT);

  // Main sequencer; the scan states are entered only from reset.
  // Host writes are refused until the load is done, because a write during
  // the scan could race the write-back of a corrected word.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SCAN_RD: begin
        if (single_err) begin
          state_next = ST_SCAN_WR;
        end else if (addr_reg == 7'(MEM_WORDS - 1)) begin
          state_next = ST_INIT;
        end
      end
      ST_SCAN_WR: state_next = (addr_reg == 7'(MEM_WORDS - 1)) ?
        ST_INIT : ST_SCAN_RD;
      ST_INIT: if (addr_reg == CONFIG_LAST) state_next = ST_OFFSET;
      ST_OFFSET: if (ir_full && amb_full && ofs_time_up) begin
        state_next = ST_MEASURE;
      end
      ST_MEASURE: if (ir_full && amb_full) state_next = ST_LINEAR;
      ST_LINEAR: state_next = ST_COMPARE;
      ST_COMPARE: state_next = intv_due ? ST_OFFSET : ST_MEASURE;
      default: state_next = ST_SCAN_RD;
    endcase
  end

  // Memory has no reset; its content survives power-on reset by nature.
  // A plain always is used because the cells are non-volatile and may be
  // placed from outside this process before reset is released.
  always @(posedge CLK_SYS_IN) begin
    if (state_reg == ST_SCAN_WR) begin
      mem[addr_reg] <= fix_reg;
    end else if (host_wr_ok) begin
      mem[HOST_ADDR_IN] <= HOST_WDATA_IN;
    end
  end

  // Scan pointer, fatal flag and configuration load.
  // A single error costs a second cycle for the write-back; the pointer
  // only moves on once the corrected word is stored.
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_reg <= ST_SCAN_RD;
      addr_reg <= 7'h00;
      fatal_reg <= 1'b0;
      fix_reg <= 16'h0000;
      done_reg <= 1'b0;
      for (int i = 0; i < 8; i++) cfg_reg[i] <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_SCAN_RD) begin
        fix_reg <= word ^ flip_mask(syndrome);
        if (double_err) fatal_reg <= 1'b1;
        if (!single_err) addr_reg <= addr_reg + 7'h01;
      end else if (state_reg == ST_SCAN_WR) begin
        addr_reg <= addr_reg + 7'h01;
      end else if (state_reg == ST_INIT) begin
        cfg_reg[addr_reg[2:0]] <= word;
        addr_reg <= addr_reg + 7'h01;
        done_reg <= (addr_reg == CONFIG_LAST);
      end
    end
  end

  // Sample accumulation, offsets and offset-free results.
  // Accumulators are 22 bits: 1024 samples of 12 bits fit them exactly.
  // Samples that arrive after a channel is full are dropped, not queued.
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ir_acc_reg <= 22'h000000;
      amb_acc_reg <= 22'h000000;
      ir_cnt_reg <= 11'h000;
      amb_cnt_reg <= 11'h000;
      ir_ofs_reg <= RESULT_RESET;
      amb_ofs_reg <= RESULT_RESET;
      ir_res_reg <= RESULT_RESET;
      amb_res_reg <= RESULT_RESET;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      if (ir_take) begin
        ir_acc_reg <= ir_acc_reg + 22'(IR_SAMPLE_IN);
        ir_cnt_reg <= ir_cnt_reg + 11'h001;
      end
      if (amb_take) begin
        amb_acc_reg <= amb_acc_reg + 22'(AMB_SAMPLE_IN);
        amb_cnt_reg <= amb_cnt_reg + 11'h001;
      end
      if (state_reg != state_next && collecting) begin
        ir_acc_reg <= 22'h000000;
        amb_acc_reg <= 22'h000000;
        ir_cnt_reg <= 11'h000;
        amb_cnt_reg <= 11'h000;
        if (offset_phase) begin
          ir_ofs_reg <= ir_mean;
          amb_ofs_reg <= amb_mean;
        end else begin
          ir_res_reg <= ir_free;
          amb_res_reg <= amb_free;
          valid_reg <= 1'b1;
        end
      end
    end
  end

  // Offset duration timer and interval timer between offset runs.
  // The interval timer is 29 bits: sixteen base intervals at the full clock
  // rate overflow 28 bits and would wrap to a far shorter interval.
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      time_reg <= 23'h000000;
      intv_reg <= 29'h00000000;
    end else begin
      time_reg <= offset_phase ? (ofs_time_up ? time_reg :
        time_reg + 23'h000001) : 23'h000000;
      intv_reg <= offset_phase ? 29'h00000000 :
        (intv_due ? intv_reg : intv_reg + 29'h00000001);
    end
  end

  // Registered outputs; results only change when a measurement completes,
  // so they hold through any offset run.
  // Status bits other than the fatal flag are spare and read as zero.
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      IR_RESULT_OUT <= RESULT_RESET;
      AMB_RESULT_OUT <= RESULT_RESET;
      IR_OFFSET_OUT <= RESULT_RESET;
      AMB_OFFSET_OUT <= RESULT_RESET;
      STATUS_OUT <= STATUS_RESET;
      RESULT_VALID_OUT <= 1'b0;
      OFFSET_BUSY_OUT <= 1'b0;
      SCAN_DONE_OUT <= 1'b0;
      HOST_RDATA_OUT <= 16'h0000;
      for (int i = 0; i < 8; i++) CONFIG_WORD_OUT[i] <= 16'h0000;
    end else begin
      if (!offset_phase) begin
        IR_RESULT_OUT <= ir_res_reg;
        AMB_RESULT_OUT <= amb_res_reg;
        RESULT_VALID_OUT <= valid_reg;
      end else begin
        RESULT_VALID_OUT <= 1'b0;
      end
      IR_OFFSET_OUT <= ir_ofs_reg;
      AMB_OFFSET_OUT <= amb_ofs_reg;
      STATUS_OUT <= {2'b00, fatal_reg, 1'b0};
      OFFSET_BUSY_OUT <= offset_phase;
      SCAN_DONE_OUT <= done_reg || SCAN_DONE_OUT;
      HOST_RDATA_OUT <= mem[HOST_ADDR_IN];
      for (int i = 0; i < 8; i++) CONFIG_WORD_OUT[i] <= cfg_reg[i];
    end
  end

endmodule // ecc_startup_sequencer

/* File: tb/ecc_startup_sequencer_checker.sv */
// Port-level assertions for the correction scan and measurement sequencer.
// Assumes one clock domain; bound onto every sequencer instance below.
module ecc_startup_sequencer_checker #(
  parameter int unsigned OFS_SMALL_CYCLES = 50
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic [15:0] IR_RESULT_OUT,
  input wire logic [15:0] AMB_RESULT_OUT,
  input wire logic [3:0] STATUS_OUT,
  input wire logic RESULT_VALID_OUT,
  input wire logic OFFSET_BUSY_OUT,
  input wire logic SCAN_DONE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned busy_cnt;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);
  // Length of the current offset run; it saturates so it cannot wrap.
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) busy_cnt <= 0;
    else if (!OFFSET_BUSY_OUT) busy_cnt <= 0;
    else if (busy_cnt < 32'hFFFF) busy_cnt <= busy_cnt + 1;
  end
  chk_status_spare_zero: assert property (
    STATUS_OUT[3:2] == 2'h0 && STATUS_OUT[0] == 1'b0)
    else $error("status spare bits not zero");
  chk_fatal_flag_sticky: assert property (
    STATUS_OUT[1] |=> STATUS_OUT[1]) else $error("fatal flag dropped");
  chk_scan_once_only: assert property (
    SCAN_DONE_OUT |=> SCAN_DONE_OUT) else $error("scan done dropped");
  chk_hold_during_offset: assert property (
    OFFSET_BUSY_OUT |=> $stable(IR_RESULT_OUT) && $stable(AMB_RESULT_OUT))
    else $error("result moved during offset run");
  chk_no_result_busy: assert property (
    OFFSET_BUSY_OUT |-> !RESULT_VALID_OUT)
    else $error("result strobe during offset run");
  chk_valid_one_cycle: assert property (
    RESULT_VALID_OUT |=> !RESULT_VALID_OUT) else $error("long result strobe");
  chk_order_after_scan: assert property (
    !SCAN_DONE_OUT |-> !OFFSET_BUSY_OUT && !RESULT_VALID_OUT)
    else $error("measuring before scan and load");
  chk_offset_min_len: assert property (
    $fell(OFFSET_BUSY_OUT) |-> busy_cnt >= OFS_SMALL_CYCLES)
    else $error("offset run too short");
endmodule // ecc_startup_sequencer_checker

bind ecc_startup_sequencer ecc_startup_sequencer_checker #(
  .OFS_SMALL_CYCLES(OFS_SMALL_CYCLES)
) u_chk (.CLK_SYS_IN, .RESET_N_IN, .IR_RESULT_OUT, .AMB_RESULT_OUT,
  .STATUS_OUT, .RESULT_VALID_OUT, .OFFSET_BUSY_OUT, .SCAN_DONE_OUT);

/* File: tb/ecc_host_model.sv */
// Host that programs and reads the coded memory words.
// Assumes the sequencer registers read data one cycle after the address.
module ecc_host_model (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic wr_out,
  output logic [6:0] addr_out,
  output logic [15:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_out = 1'b0;
    addr_out = 7'h00;
    wdata_out = 16'h0000;
  end
  // The device never codes a word itself, so the host must do it.
  function automatic logic [15:0] encode(input logic [10:0] d);
    logic [3:0] h;
    h[0] = ^{d[0], d[1], d[3], d[4], d[6], d[8], d[10]};
    h[1] = ^{d[0], d[2], d[3], d[5], d[6], d[9], d[10]};
    h[2] = ^{d[1], d[2], d[3], d[7], d[8], d[9], d[10]};
    h[3] = ^{d[4], d[5], d[6], d[7], d[8], d[9], d[10]};
    return {d, ^{d, h}, h};
  endfunction
  // Whole-word write; reserved bits are the caller's to preserve.
  task automatic write_word(input logic [6:0] a, input logic [10:0] d);
    @(negedge clk_in);
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = encode(d);
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~wdata_out;
  endtask
  // Returns the raw word and its payload, the word shifted right by five.
  task automatic read_word(input logic [6:0] a, output logic [15:0] w,
                           output logic [10:0] p);
    @(negedge clk_in);
    addr_out = a;
    @(negedge clk_in);
    @(negedge clk_in);
    w = rdata_in;
    p = 11'(rdata_in >> 5);
  endtask
endmodule // ecc_host_model

/* File: tb/ecc_startup_sequencer_tb.sv */
// Self-checking bench for the correction scan and measurement sequencer.
// Assumes the memory array is reachable as mem[] for preloading.
module ecc_startup_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ecc_seq_pkg::*;
  logic clk, rst_n, wr, ir_v, amb_v, rv, busy, done;
  logic [6:0] addr;
  logic [15:0] wdata, rdata, ir_res, amb_res, ir_ofs, amb_ofs, w;
  logic [11:0] ir_s, amb_s;
  logic [3:0] status;
  logic [15:0] cfg [0:7];
  logic [15:0] exp_mem [0:127];
  logic [10:0] p;
  int err_count, num_checks, cycles, n;
  ecc_host_model u_ecc_host_model (.clk_in(clk), .rdata_in(rdata),
    .wr_out(wr), .addr_out(addr), .wdata_out(wdata));
  ecc_startup_sequencer #(.OFS_SMALL_CYCLES(50), .OFS_LARGE_CYCLES(100),
    .INTERVAL_CYCLES(200)) u_ecc_startup_sequencer (.CLK_SYS_IN(clk),
    .RESET_N_IN(rst_n), .HOST_WR_IN(wr), .HOST_ADDR_IN(addr),
    .HOST_WDATA_IN(wdata), .HOST_RDATA_OUT(rdata),
    .IR_SAMPLE_VALID_IN(ir_v), .IR_SAMPLE_IN(ir_s),
    .AMB_SAMPLE_VALID_IN(amb_v), .AMB_SAMPLE_IN(amb_s),
    .IR_RESULT_OUT(ir_res), .AMB_RESULT_OUT(amb_res),
    .IR_OFFSET_OUT(ir_ofs), .AMB_OFFSET_OUT(amb_ofs), .STATUS_OUT(status),
    .RESULT_VALID_OUT(rv), .OFFSET_BUSY_OUT(busy), .SCAN_DONE_OUT(done),
    .CONFIG_WORD_OUT(cfg));
  // Clock at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Converter samples: a low level while offsetting, a higher one otherwise.
  always @(negedge clk) begin
    ir_s <= busy ? 12'h064 : 12'h12C;
    amb_s <= busy ? 12'h028 : 12'h05A;
  end
  // Hang guard; the whole run needs well under this many cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // The busy flag lags the phase by a cycle, so the first sample of an offset
  // run and of the following measurement carries the other level; the first result after an offset run is
  // skipped and the second, made of measurement samples only, is checked.
  task automatic check_results();
    repeat (2) begin
      @(negedge clk);
      for (n = 0; n < 3000 && rv !== 1'b1; n++) @(posedge clk);
    end
    @(negedge clk);
    check(ir_ofs, 16'h0064, "ir offset");
    check(amb_ofs, 16'h0028, "amb offset");
    check(ir_res, 16'h00C8, "ir result");
    check(amb_res, 16'h0032, "amb result");
  endtask
  // Main sequence: preload, scan, load, then the measurement loop.
  initial begin
    rst_n = 1'b0;
    ir_v = 1'b1;
    amb_v = 1'b1;
    #1;
    // Words 04h and 07h stay zero: shortest interval and counts.
    for (int i = 0; i < 128; i++) begin
      exp_mem[i] = u_ecc_host_model.encode((i == 4 || i == 7) ? 11'h000
                                            : 11'(i * 13 + 1));
      u_ecc_startup_sequencer.mem[i] = exp_mem[i];
    end
    u_ecc_startup_sequencer.mem[10] = exp_mem[10] ^ 16'h0100;
    u_ecc_startup_sequencer.mem[11] = exp_mem[11] ^ 16'h0003;
    u_ecc_startup_sequencer.mem[12] = exp_mem[12] ^ 16'h0010;
    repeat (8) @(negedge clk);
    check({11'h000, done, status}, 16'h0000, "reset outputs");
    rst_n = 1'b1;
    u_ecc_host_model.write_word(7'h78, 11'h555);
    for (n = 0; n < 400 && done !== 1'b1; n++) @(posedge clk);
    @(negedge clk);
    check(16'(done), 16'h0001, "scan done");
    check(16'(status), 16'h0002, "fatal flag");
    for (int i = 0; i < 8; i++) check(cfg[i], exp_mem[i], "config");
    u_ecc_host_model.read_word(7'h0A, w, p);
    check(w, exp_mem[10], "data bit fixed");
    u_ecc_host_model.read_word(7'h0B, w, p);
    check(w, exp_mem[11] ^ 16'h0003, "double left");
    u_ecc_host_model.read_word(7'h0C, w, p);
    check(w, exp_mem[12], "parity bit fixed");
    u_ecc_host_model.read_word(7'h78, w, p);
    check(w, exp_mem[120], "write during scan");
    u_ecc_host_model.write_word(7'h78, 11'h555);
    u_ecc_host_model.read_word(7'h78, w, p);
    check(w, 16'hAAA5, "written word");
    check(16'(p), 16'h0555, "payload");
    check_results();
    for (n = 0; n < 2000 && busy !== 1'b1; n++) @(posedge clk);
    @(negedge clk);
    check(16'(busy), 16'h0001, "offset repeats");
    check_results();
    finish_test();
  end
endmodule // ecc_startup_sequencer_tb
